// ===== verif/dsl_host.sv
// host serial port model driving frames into the load port
`timescale 1ns/1ps
module dsl_host (
	// serial link
	output logic serial_clock_in,
	output logic frame_sync_n,
	output logic serial_data_in,
	input wire logic serial_data_out
);
	logic act = 1'b0; // capture level: 0 falling, 1 rising
	initial begin
		serial_clock_in = 1'b0;
		frame_sync_n = 1'b1;
		serial_data_in = 1'b0;
	end
	// one frame of n bits msb first; clock rests between frames
	task automatic send(input logic [15:0] w, input int n, output logic [15:0] got);
		serial_clock_in = act;
		#6 frame_sync_n = 1'b0;
		#13;
		for (int i = 15; i > 15 - n; i--) begin
			#3 serial_data_in = w[i];
			#3 serial_clock_in = ~act;
			#6 serial_clock_in = act;
			got[i] = serial_data_out;
		end
		#3 frame_sync_n = 1'b1;
		serial_data_in = ~serial_data_in; // released line must not look valid
		#30;
	endtask
endmodule

// ===== verif/dsl_top_props.sv
// assertions on the load port outputs
`timescale 1ns/1ps
module dsl_top_props
	import dsl_pkg::*;
(
	// system side
	input wire logic clock,
	input wire logic reset,
	input wire logic frame_sync_n,
	// converter and status
	input wire logic [DATA_RES-1:0] dac_code,
	input wire logic dac_update,
	input wire logic dac_ready,
	input wire logic input_buffers_on,
	input wire logic word_overrun
);
	default clocking @(posedge clock); endclocking
	default disable iff (reset);
	// buffers follow the frame after the two-flop sync
	buf_on_a: assert property ($fell(frame_sync_n) |-> ##[1:4] input_buffers_on) else $error("buffers late");
	buf_held_a: assert property (!frame_sync_n [*4] |-> input_buffers_on) else $error("buffers off");
	buf_off_a: assert property ($rose(frame_sync_n) |-> ##[1:4] !input_buffers_on) else $error("buffers stay");
	buf_idle_a: assert property (frame_sync_n [*4] |-> !input_buffers_on) else $error("buffers idle on");
	// the code moves only with its pulse, and only when taken
	code_upd_a: assert property ($changed(dac_code) |-> dac_update) else $error("code moved");
	upd_ready_a: assert property (dac_update |-> $past(dac_ready)) else $error("update unready");
	// reset clears the code and the overrun flag; overrun is sticky until reset
	rst_clear_a: assert property ($fell(reset) |-> dac_code == CODE_RESET && !word_overrun) else $error("reset");
	ovr_stick_a: assert property (word_overrun |=> word_overrun) else $error("overrun lost");
endmodule
////////////////////////////////////////
bind dsl_top dsl_top_props i_props (.*);

// ===== verif/dsl_top_tb_top.sv
// bench: scenarios on the load port through the host model
`timescale 1ns/1ps
module dsl_top_tb_top
	import dsl_pkg::*;
;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic dac_ready = 1'b1;
	logic serial_clock_in, frame_sync_n, serial_data_in, serial_data_out;
	logic dac_update, input_buffers_on, word_overrun;
	logic [DATA_RES-1:0] dac_code;
	logic [15:0] got;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	int ups = 0;
	////////////////////////////////////////
	// clock, ceiling and update count
	always #12.5 clock = ~clock;
	always @(posedge clock) begin
		cycles <= cycles + 1;
		ups <= ups + int'(dac_update);
		if (cycles == 5000) begin
			num_errors++;
			close_out();
		end
	end
	dsl_top i_dsl_top (.*);
	dsl_host i_dsl_host (.*);
	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
		checks_done++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one frame, then room for the word to cross
	task automatic frame(input logic [3:0] c, input logic [11:0] f, input int n);
		i_dsl_host.send({c, f}, n, got);
		repeat (12) @(posedge clock);
	endtask
	task automatic close_out();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	task automatic t_load();
		int u;
		u = ups;
		frame(CTRL_LOAD, 12'hA5C, 16);
		check("dac_code", 16'h0A5C, 16'(dac_code));
		check("updates", 16'(u + 1), 16'(ups));
		check("chain_reset", 16'h0000, got);
		frame(CTRL_LOAD, 12'h3C1, 16);
		check("chain", 16'h1A5C, got);
	endtask
	task automatic t_modes();
		int u;
		frame(CTRL_READBACK, 12'h000, 16);
		frame(CTRL_LOAD, 12'h777, 16);
		check("readback", 16'h03C1, got);
		frame(CTRL_EDGE_RISE, 12'h000, 16);
		i_dsl_host.act = 1'b1;
		frame(CTRL_LOAD, 12'h5A5, 16);
		check("dac_code", 16'h05A5, 16'(dac_code));
		frame(CTRL_EDGE_FALL, 12'h000, 16);
		i_dsl_host.act = 1'b0;
		u = ups;
		frame(CTRL_LOAD, 12'hFFF, 15);
		check("short", 16'(u), 16'(ups));
		// an undefined control code must latch nothing
		frame(4'h0, 12'h123, 16);
		check("unknown", 16'(u), 16'(ups));
		check("dac_code", 16'h05A5, 16'(dac_code));
	endtask
	// fifo plus hold stage fill, the next word is lost
	task automatic t_overrun();
		dac_ready <= 1'b0;
		for (int k = 1; k <= 34; k++) frame(CTRL_LOAD, 12'(k), 16);
		check("word_overrun", 16'h0001, 16'(word_overrun));
		dac_ready <= 1'b1;
		repeat (60) @(posedge clock);
		check("dac_code", 16'h0021, 16'(dac_code));
	endtask
	initial begin
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		repeat (2) @(posedge clock);
		check("dac_code", 16'(CODE_RESET), 16'(dac_code));
		t_load();
		t_modes();
		t_overrun();
		close_out();
	end
endmodule

// ===== verilog/dsl_pkg.sv
// package: constants, codes and carrier types of the serial load port
//
// Contract
// - capture serial_data_in on serial_clock_in falling edge after power-up by default
// - control word may switch capture to the rising serial_clock_in edge
// - sixteen-bit input shift register takes one bit per active edge in a frame
// - frame_sync_n low opens a frame, powers input buffers, enables shifting
// - standalone mode counts active edges and latches the word on the 16th
// - serial_data_out changes on the edge opposite to the capture edge
// - readback control word presents converter register contents on serial_data_out
// - shift register data passes out on serial_data_out for daisy-chaining
// - word is four control bits followed by the converter data field
// - data field used at variant resolution, trailing unused bits ignored
// - frame_sync_n rising powers down the serial clock and data input buffers
package dsl_pkg;

	////////////////////////////////////////////////////////////////////////////
	// word layout
	localparam int WORD_BITS = 16;
	localparam int CTRL_BITS = 4;
	localparam int FIELD_BITS = 12;
	localparam int CTRL_MSB = 15;
	localparam int CTRL_LSB = 12;
	localparam int FIELD_MSB = 11;
	localparam int DATA_RES = 12;
	localparam int FIFO_DEPTH = 32;
	localparam int CNT_BITS = 5;
	localparam logic [CNT_BITS-1:0] EDGE_COUNT = 5'h10;

	////////////////////////////////////////////////////////////////////////////
	// control codes
	localparam logic [CTRL_BITS-1:0] CTRL_LOAD = 4'h1;
	localparam logic [CTRL_BITS-1:0] CTRL_READBACK = 4'h2;
	localparam logic [CTRL_BITS-1:0] CTRL_EDGE_RISE = 4'hD;
	localparam logic [CTRL_BITS-1:0] CTRL_EDGE_FALL = 4'hE;

	////////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [WORD_BITS-1:0] WORD_RESET = 16'h0000;
	localparam logic [DATA_RES-1:0] CODE_RESET = 12'h000;

	////////////////////////////////////////////////////////////////////////////
	// carrier types
	typedef struct packed {
		logic [CTRL_BITS-1:0] ctrl;
		logic [FIELD_BITS-1:0] field;
	} dsl_word_t;

	typedef enum logic [1:0] {
		DSL_IDLE = 2'b00,
		DSL_HOLD = 2'b01
	} dsl_cap_t;

endpackage

// ===== verilog/dsl_top.sv
// file: word fifo and the serial load port top
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// single-clock fifo with valid/ready on both sides
module dsl_fifo #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 32
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [AW:0] wr;
		logic [AW:0] rd;
	} dsl_fifo_st_t;

	dsl_fifo_st_t s_q, s_d;
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic full, empty, do_wr, do_rd;

	// full when pointers differ only in the wrap bit
	assign full = (s_q.wr[AW] != s_q.rd[AW]) && (s_q.wr[AW-1:0] == s_q.rd[AW-1:0]);
	assign empty = (s_q.wr == s_q.rd);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign do_wr = in_valid && !full;
	assign do_rd = out_ready && !empty;
	assign out_data = mem_q[s_q.rd[AW-1:0]];

	// pointer update
	always_comb begin
		s_d = s_q;
		if (do_wr) begin
			s_d.wr = s_q.wr + 1'b1;
		end
		if (do_rd) begin
			s_d.rd = s_q.rd + 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	// storage has no reset; nothing reads a slot before it is written
	always_ff @(posedge clock) begin
		if (do_wr) begin
			mem_q[s_q.wr[AW-1:0]] <= in_data;
		end
	end
endmodule

////////////////////////////////////////////////////////////////////////////////
// serial load port: link logic on the serial clock, converter register on clock
module dsl_top
	import dsl_pkg::*;
(
	// system clock and reset
	input wire logic clock,
	input wire logic reset,
	// serial link from the host
	input wire logic serial_clock_in,
	input wire logic frame_sync_n,
	input wire logic serial_data_in,
	output logic serial_data_out,
	// converter side
	output logic [DATA_RES-1:0] dac_code,
	output logic dac_update,
	input wire logic dac_ready,
	// status
	output logic input_buffers_on,
	output logic word_overrun
);

	////////////////////////////////////////////////////////////////////////////
	// link domain state
	typedef struct packed {
		logic [WORD_BITS-1:0] shift;
		logic [WORD_BITS-1:0] word;
		logic [FIELD_BITS-1:0] conv;
		logic tog;
		logic edge_rise_pend;
	} dsl_lk_st_t;

	dsl_lk_st_t lk_q, lk_d;
	logic [CNT_BITS-1:0] cnt_q;
	logic edge_rise_q;
	logic sdo_q;
	logic cap_clk;
	logic frame_open;
	logic last_edge;
	logic [WORD_BITS-1:0] shifted;
	dsl_word_t rx;

	// the active edge is always a falling edge of cap_clk; edge select flips
	// only while the frame is closed, so the flip cannot land mid-word
	assign cap_clk = serial_clock_in ^ edge_rise_q;
	assign frame_open = !frame_sync_n;
	assign last_edge = (cnt_q == EDGE_COUNT - 5'h01);
	assign shifted = {lk_q.shift[WORD_BITS-2:0], serial_data_in};
	assign rx = dsl_word_t'(shifted);

	// active-edge counter, held cleared while the frame is closed
	always_ff @(negedge cap_clk or posedge frame_sync_n) begin
		if (frame_sync_n) begin
			cnt_q <= '0;
		end else if (cnt_q != EDGE_COUNT) begin
			cnt_q <= cnt_q + 5'h01;
		end
	end

	// capture, latch on the 16th edge, decode of the control field
	always_comb begin
		lk_d = lk_q;
		if (frame_open) begin
			lk_d.shift = shifted;
			if (last_edge) begin
				lk_d.word = shifted;
				case (rx.ctrl)
					CTRL_LOAD: begin
						lk_d.conv = rx.field;
						lk_d.tog = !lk_q.tog;
					end
					CTRL_READBACK: begin
						// preload so the next frame shifts the register out
						lk_d.shift = {{CTRL_BITS{1'b0}}, lk_q.conv};
					end
					CTRL_EDGE_RISE: begin
						lk_d.edge_rise_pend = 1'b1;
					end
					CTRL_EDGE_FALL: begin
						lk_d.edge_rise_pend = 1'b0;
					end
					default: begin
						lk_d.word = lk_q.word;
					end
				endcase
			end
		end
	end

	// power-on reset only; the link clock may be still at that time
	always_ff @(negedge cap_clk or posedge reset) begin
		if (reset) begin
			lk_q <= '0;
		end else begin
			lk_q <= lk_d;
		end
	end

	// output bit moves on the edge opposite the capture edge
	always_ff @(posedge cap_clk or posedge reset) begin
		if (reset) begin
			sdo_q <= 1'b0;
		end else begin
			sdo_q <= lk_q.shift[WORD_BITS-1];
		end
	end

	assign serial_data_out = sdo_q;

	// edge choice takes effect when the frame closes
	always_ff @(posedge frame_sync_n or posedge reset) begin
		if (reset) begin
			edge_rise_q <= 1'b0;
		end else begin
			edge_rise_q <= lk_q.edge_rise_pend;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// system domain state
	typedef struct packed {
		logic [2:0] tog_sync;
		logic [1:0] fs_sync;
		dsl_cap_t cap;
		logic [WORD_BITS-1:0] hold;
		logic overrun;
		logic [DATA_RES-1:0] code;
		logic update;
	} dsl_sys_st_t;

	dsl_sys_st_t s_q, s_d;
	logic new_word;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [WORD_BITS-1:0] fifo_out_data;
	dsl_word_t fw;

	// toggle crossing: the word is stable for a whole frame after the toggle
	assign new_word = s_q.tog_sync[2] ^ s_q.tog_sync[1];
	assign fifo_out_ready = dac_ready;
	assign fw = dsl_word_t'(fifo_out_data);

	always_comb begin
		s_d = s_q;
		s_d.tog_sync = {s_q.tog_sync[1:0], lk_q.tog};
		s_d.fs_sync = {s_q.fs_sync[0], frame_sync_n};
		s_d.update = 1'b0;
		// hold stage waits for fifo room; a word arriving meanwhile is lost
		case (s_q.cap)
			DSL_IDLE: begin
				if (new_word) begin
					s_d.hold = lk_q.word;
					s_d.cap = DSL_HOLD;
				end
			end
			DSL_HOLD: begin
				if (fifo_in_ready) begin
					s_d.cap = DSL_IDLE;
				end
				if (new_word) begin
					s_d.overrun = 1'b1;
				end
			end
			default: begin
				s_d.cap = DSL_IDLE;
			end
		endcase
		if (fifo_out_valid && dac_ready) begin
			// top bits of the field are the code; trailing bits ignored
			s_d.code = fw.field[FIELD_MSB -: DATA_RES];
			s_d.update = 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			s_q <= '0;
			s_q.fs_sync <= 2'b11;
			s_q.code <= CODE_RESET;
		end else begin
			s_q <= s_d;
		end
	end

	dsl_fifo #(
		.WIDTH(WORD_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clock(clock),
		.reset(reset),
		.in_valid(s_q.cap == DSL_HOLD),
		.in_ready(fifo_in_ready),
		.in_data(s_q.hold),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	assign dac_code = s_q.code;
	assign dac_update = s_q.update;
	assign input_buffers_on = !s_q.fs_sync[1];
	assign word_overrun = s_q.overrun;
endmodule
